// [core/dil_defs.vh]
// Constants for the interrupt latch and multiplexer block.
// Assumes inclusion by the design files only; definitions only.
`ifndef DIL_DEFS_VH
`define DIL_DEFS_VH

// ----------------------------------------
// Register offsets (word index, byte address = 4 * index)
// ----------------------------------------
`define DIL_OFF_CTRL 4'h0
`define DIL_OFF_STATUS 4'h1
`define DIL_OFF_SERVICE 4'h2
`define DIL_OFF_CORE 4'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DIL_CTRL_FLAG_LSB 0
`define DIL_CTRL_EN_LSB 4
`define DIL_CTRL_FRAMING_BIT 9
`define DIL_CTRL_COPROC_BIT 12
`define DIL_CTRL_RESET 32'h00000000

// ----------------------------------------
// Source indices
// ----------------------------------------
`define DIL_SRC_EXT 0
`define DIL_SRC_RX 1
`define DIL_SRC_TX 2
`define DIL_SRC_FR 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define DIL_VECTOR 12'h002
`define DIL_VECTOR_CYCLES 4
`define DIL_COPROC_HOLD 3'h4

`endif

// [core/dil_sync.v]
// Two-flop synchroniser for a vector of asynchronous inputs.
// Assumes the inputs come from outside the ref_clk domain.
`timescale 1ns/1ns
module dil_sync #(
    parameter WIDTH = 4
) (
    input wire ref_clk,
    input wire reset,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] reset_val,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            // Idle level per line, so release shows no false edge
            meta_q <= reset_val;
            sync_out <= reset_val;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // dil_sync

// [core/dil_edge.v]
// Falling-edge detector per source, on synchronised levels.
// Assumes inputs are already in the ref_clk domain.
`timescale 1ns/1ns
module dil_edge #(
    parameter WIDTH = 4
) (
    input wire ref_clk,
    input wire reset,
    input wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] fall_pulse
);
    reg [WIDTH-1:0] prev_q;
    genvar i;

    // Follows the input through reset, so release never looks like an edge
    always @(posedge ref_clk)
    begin
        prev_q <= level_in;
    end

    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_edge
            assign fall_pulse[i] = prev_q[i] & ~level_in[i] & ~reset;
        end
    endgenerate
endmodule // dil_edge

// [core/dil_latch_mux.v]
// Interrupt latch and multiplexer with core-side service sequencer.
// Assumes the core reports instruction boundaries on ref_clk (10 MHz);
// pins are asynchronous and synchronised here. Registers over Avalon-MM.
`timescale 1ns/1ns
`include "dil_defs.vh"
module dil_latch_mux #(
    parameter PC_W = 12
) (
    input wire ref_clk,
    input wire reset,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Pins, asynchronous and active low except the frame pulse
    input wire external_request_n,
    input wire rx_frame_sync_n,
    input wire tx_frame_sync_n,
    input wire internal_frame_pulse,
    input wire host_rd_n,
    input wire host_wr_n,
    input wire branch_test_in_n,
    // Core side, same clock
    input wire enable_irq_instr,
    input wire disable_irq_instr,
    input wire load_status_instr,
    input wire instr_boundary,
    input wire multicycle_busy,
    input wire multiply_instr,
    input wire [PC_W-1:0] core_pc,
    output reg irq_take,
    output reg discard_fetch,
    output reg stack_push,
    output reg [PC_W-1:0] stack_top,
    output reg pc_load,
    output reg [PC_W-1:0] pc_vector,
    output reg global_irq_mask,
    output reg master_irq,
    output reg branch_test_eff_n
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ACK = 5'h02;
    localparam [4:0] ST_MASK = 5'h04;
    localparam [4:0] ST_PUSH = 5'h08;
    localparam [4:0] ST_LOAD = 5'h10;

    reg [4:0] state_q;
    reg [3:0] flag_q;
    reg [3:0] enable_q;
    reg framing_sel_q;
    reg coproc_q;
    reg defer_mul_q;
    reg defer_ei_q;
    reg [2:0] hold_q;
    reg rd_prev_q;
    reg [2:0] wait_q;

    wire [3:0] pin_async;
    wire [3:0] pin_sync;
    wire [2:0] host_sync;
    wire [3:0] src_fall;
    wire [3:0] src_level;
    wire ext_low;
    wire host_rd_rise;
    wire [3:0] set_ev;
    wire [3:0] sw_clr;
    wire [3:0] can_clr;
    wire ctrl_wr;
    wire take_ok;
    wire irq_active;

    // ----------------------------------------
    // Synchronisers and edge detection
    // ----------------------------------------
    assign pin_async = {internal_frame_pulse, tx_frame_sync_n, rx_frame_sync_n,
                        external_request_n};

    dil_sync #(.WIDTH(4)) u_sync_pins (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(pin_async),
        .reset_val(4'h7),
        .sync_out(pin_sync)
    );

    dil_sync #(.WIDTH(3)) u_sync_host (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({branch_test_in_n, host_wr_n, host_rd_n}),
        .reset_val(3'h7),
        .sync_out(host_sync)
    );

    // Frame pulse idles low; its falling edge ends the pulse and is the event
    // In coprocessor mode the master's write strobe stands in for the pin
    assign src_level = {pin_sync[3], pin_sync[2], pin_sync[1],
                        coproc_q ? host_sync[1] : pin_sync[0]};

    dil_edge #(.WIDTH(4)) u_edge (
        .ref_clk(ref_clk),
        .reset(reset),
        .level_in(src_level),
        .fall_pulse(src_fall)
    );

    assign ext_low = ~coproc_q & ~pin_sync[0];
    assign host_rd_rise = host_sync[0] & ~rd_prev_q;

    // ----------------------------------------
    // Flag set and clear
    // ----------------------------------------
    assign set_ev[`DIL_SRC_EXT] = src_fall[0] | ext_low;
    // Frame inputs only interrupt when internal framing owns the port
    assign set_ev[`DIL_SRC_RX] = src_fall[1] & ~framing_sel_q;
    assign set_ev[`DIL_SRC_TX] = src_fall[2] & ~framing_sel_q;
    // Frame pulse runs as a timer when external framing is selected
    assign set_ev[`DIL_SRC_FR] = src_fall[3] & framing_sel_q;

    assign ctrl_wr = avs_write & ~avs_waitrequest &
                     (avs_address == `DIL_OFF_CTRL) & avs_byteenable[0];
    assign sw_clr = ctrl_wr ? ~avs_writedata[3:0] : 4'h0;
    // A read still in the synchroniser blocks the clear before the hold starts
    assign can_clr[0] = ~ext_low & (hold_q == 3'h0) & ~(coproc_q & ~host_sync[0]);
    assign can_clr[3:1] = 3'h7;

    always @(posedge ref_clk)
    begin
        if (reset)
            rd_prev_q <= 1'b1;
        else
            rd_prev_q <= host_sync[0];
    end

    always @(posedge ref_clk)
    begin
        if (reset)
            hold_q <= 3'h0;
        else if (coproc_q && host_rd_rise)
            hold_q <= `DIL_COPROC_HOLD;
        else if (hold_q != 3'h0)
            hold_q <= hold_q - 3'h1;
    end

    // Set wins over clear in the same cycle
    always @(posedge ref_clk)
    begin
        if (reset)
            flag_q <= 4'h0;
        else
            flag_q <= set_ev | (flag_q & ~(sw_clr & can_clr)
                      & ~((state_q == ST_ACK) ? (4'h1 & can_clr) : 4'h0));
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            enable_q <= 4'h0;
            framing_sel_q <= 1'b0;
            coproc_q <= 1'b0;
        end
        else if (avs_write && !avs_waitrequest && avs_address == `DIL_OFF_CTRL)
        begin
            if (avs_byteenable[0])
                enable_q <= avs_writedata[7:4];
            if (avs_byteenable[1])
            begin
                framing_sel_q <= avs_writedata[`DIL_CTRL_FRAMING_BIT];
                coproc_q <= avs_writedata[`DIL_CTRL_COPROC_BIT];
            end
        end
    end

    // ----------------------------------------
    // Combine and mask
    // ----------------------------------------
    assign irq_active = |(flag_q & enable_q);
    // Service only at an instruction boundary outside all deferrals
    assign take_ok = instr_boundary & ~multicycle_busy & ~defer_mul_q & ~defer_ei_q;

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            defer_mul_q <= 1'b0;
            defer_ei_q <= 1'b0;
        end
        else
        begin
            if (multiply_instr)
                defer_mul_q <= 1'b1;
            else if (instr_boundary)
                defer_mul_q <= 1'b0;
            if (enable_irq_instr && global_irq_mask)
                defer_ei_q <= 1'b1;
            else if (instr_boundary)
                defer_ei_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Service sequencer
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            wait_q <= 3'h0;
            global_irq_mask <= 1'b1;
            irq_take <= 1'b0;
            discard_fetch <= 1'b0;
            stack_push <= 1'b0;
            stack_top <= {PC_W{1'b0}};
            pc_load <= 1'b0;
            pc_vector <= {PC_W{1'b0}};
            master_irq <= 1'b0;
        end
        else
        begin
            irq_take <= 1'b0;
            discard_fetch <= 1'b0;
            stack_push <= 1'b0;
            pc_load <= 1'b0;
            master_irq <= irq_active & ~global_irq_mask;
            if (disable_irq_instr)
                global_irq_mask <= 1'b1;
            case (state_q)
                ST_IDLE:
                begin
                    // Status load never reaches the mask
                    if (enable_irq_instr && !disable_irq_instr)
                        global_irq_mask <= 1'b0;
                    // Mask checked again: a disable one cycle back must win
                    if (master_irq && take_ok && !global_irq_mask)
                    begin
                        state_q <= ST_ACK;
                        irq_take <= 1'b1;
                        discard_fetch <= 1'b1;
                        stack_top <= core_pc;
                    end
                end
                ST_ACK:
                    state_q <= ST_MASK;
                ST_MASK:
                begin
                    global_irq_mask <= 1'b1;
                    state_q <= ST_PUSH;
                end
                ST_PUSH:
                begin
                    stack_push <= 1'b1;
                    state_q <= ST_LOAD;
                end
                ST_LOAD:
                begin
                    pc_load <= 1'b1;
                    pc_vector <= `DIL_VECTOR;
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Branch test pin, replaced by read strobe in coprocessor mode
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
            branch_test_eff_n <= 1'b1;
        else
            branch_test_eff_n <= coproc_q ? host_sync[0] : host_sync[2];
    end

    // ----------------------------------------
    // Avalon slave: one wait cycle, then answer
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read && avs_waitrequest)
            begin
                case (avs_address)
                    `DIL_OFF_CTRL:
                        avs_readdata <= {19'h00000, coproc_q, 2'h0, framing_sel_q,
                                         1'b0, enable_q, flag_q};
                    `DIL_OFF_STATUS:
                        avs_readdata <= {24'h000000, 1'b0, hold_q, master_irq,
                                         irq_active, defer_ei_q, global_irq_mask};
                    `DIL_OFF_SERVICE:
                        avs_readdata <= {27'h0000000, state_q};
                    `DIL_OFF_CORE:
                        avs_readdata <= {{(32-PC_W){1'b0}}, stack_top};
                    default:
                        avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // dil_latch_mux

// [dv/dil_latch_mux_checker.sv]
// Concurrent checks on the service sequence of dil_latch_mux.
// Assumes it is bound into dil_latch_mux; one clock, sync reset.
`timescale 1ns/1ns
module dil_latch_mux_checker #(
    parameter PC_W = 12
) (
    input wire ref_clk,
    input wire reset,
    input wire enable_irq_instr,
    input wire disable_irq_instr,
    input wire [PC_W-1:0] core_pc,
    input wire irq_take,
    input wire discard_fetch,
    input wire stack_push,
    input wire [PC_W-1:0] stack_top,
    input wire pc_load,
    input wire [PC_W-1:0] pc_vector,
    input wire global_irq_mask
);
    // ----------------------------
    // Service order and mask
    // ----------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_vector;
        irq_take |-> ##4 (pc_load && pc_vector == 12'h002);
    endproperty
    a_vector: assert property (p_vector) else $error("vector load wrong");
    property p_load_cause;
        pc_load |-> $past(irq_take, 4);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("load without take");
    property p_push;
        irq_take |-> ##3 stack_push ##1 pc_load;
    endproperty
    a_push: assert property (p_push) else $error("push out of order");
    property p_mask_set;
        irq_take |-> ##2 global_irq_mask [*3];
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set");
    property p_fetch;
        irq_take |-> discard_fetch && stack_top == $past(core_pc);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch or stack wrong");
    property p_gate;
        irq_take |-> $past(global_irq_mask) == 1'b0;
    endproperty
    a_gate: assert property (p_gate) else $error("take while masked");
    property p_enable;
        enable_irq_instr |=> !global_irq_mask;
    endproperty
    a_enable: assert property (p_enable) else $error("mask not cleared");
    property p_disable;
        disable_irq_instr |=> global_irq_mask;
    endproperty
    a_disable: assert property (p_disable) else $error("mask not set");
    c_take: cover property (irq_take ##4 pc_load);
    c_enable: cover property (enable_irq_instr ##1 !global_irq_mask);
    c_disable: cover property (disable_irq_instr ##1 global_irq_mask);
endmodule // dil_latch_mux_checker

// [dv/dil_src_model.sv]
// Far side: external source, frame pins, host strobes, test pin.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/1ns
module dil_src_model (
    input wire ref_clk,
    output wire external_request_n,
    output wire rx_frame_sync_n,
    output wire tx_frame_sync_n,
    output wire internal_frame_pulse,
    output wire host_rd_n,
    output wire host_wr_n,
    output wire branch_test_in_n
);
    // Frame pulse idles low, all other lines idle high
    logic [6:0] line_q = 7'h77;
    assign {branch_test_in_n, host_wr_n, host_rd_n, internal_frame_pulse,
        tx_frame_sync_n, rx_frame_sync_n, external_request_n} = line_q;
    // Long len mimics a slow source
    task automatic pulse(input int idx, input int len);
        line_q[idx] <= ~line_q[idx];
        repeat (len) @(posedge ref_clk);
        line_q[idx] <= ~line_q[idx];
    endtask
    task automatic set(input int idx, input logic v);
        line_q[idx] <= v;
    endtask
endmodule // dil_src_model

// [dv/dil_latch_mux_tb.sv]
// Self-checking bench for dil_latch_mux: bus, pins and core side.
// Assumes the source model and checker are compiled before it.
`timescale 1ns/1ns
module dil_latch_mux_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] rd;
    logic [31:0] cfg;
    logic [5:0] op = 6'h00;
    logic [11:0] core_pc = 12'h5A3;
    wire [31:0] avs_readdata;
    wire [11:0] stack_top, pc_vector;
    wire [6:0] pin;
    wire avs_waitrequest, irq_take, discard_fetch, stack_push, pc_load;
    wire global_irq_mask, master_irq, branch_test_eff_n;
    int fail_count = 0;
    int check_count = 0;
    int takes = 0;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irq_take === 1'b1) takes++;
    dil_src_model dil_src_model_i (.ref_clk(ref_clk), .external_request_n(pin[0]),
        .rx_frame_sync_n(pin[1]), .tx_frame_sync_n(pin[2]), .internal_frame_pulse(pin[3]),
        .host_rd_n(pin[4]), .host_wr_n(pin[5]), .branch_test_in_n(pin[6]));
    dil_latch_mux #(.PC_W(12)) dil_latch_mux_i (.ref_clk(ref_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .external_request_n(pin[0]),
        .rx_frame_sync_n(pin[1]), .tx_frame_sync_n(pin[2]), .internal_frame_pulse(pin[3]),
        .host_rd_n(pin[4]), .host_wr_n(pin[5]), .branch_test_in_n(pin[6]),
        .enable_irq_instr(op[1]), .disable_irq_instr(op[2]), .load_status_instr(op[4]),
        .instr_boundary(op[0]), .multicycle_busy(op[5]), .multiply_instr(op[3]),
        .core_pc(core_pc), .irq_take(irq_take), .discard_fetch(discard_fetch),
        .stack_push(stack_push), .stack_top(stack_top), .pc_load(pc_load),
        .pc_vector(pc_vector), .global_irq_mask(global_irq_mask),
        .master_irq(master_irq), .branch_test_eff_n(branch_test_eff_n));
    // ----------------------------
    // Tasks
    // ----------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Core side: op bits are boundary, enable, disable, multiply, status load, busy
    task automatic cyc(input logic [5:0] v);
        op <= v;
        @(posedge ref_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(6'h00);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 20)
            begin
                fail_count++;
                complete_run();
            end
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic expect_reg(input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    // ----------------------------
    // Sequence
    // ----------------------------
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        idle(2);
        chk("mask", global_irq_mask, 32'h1);
        expect_reg(4'h1, 32'h1, 32'h1, "status mask");
        expect_reg(4'h2, 32'h1F, 32'h01, "service idle");
        expect_reg(4'h0, 32'hFFFFFFFF, 32'h0, "ctrl");
        bus(1'b1, 4'h7, 32'hFFFF);
        expect_reg(4'h7, 32'hFFFFFFFF, 32'h0, "unmapped");
        bus(1'b1, 4'h0, 32'h10);
        dil_src_model_i.pulse(0, 3);
        idle(6);
        expect_reg(4'h0, 32'hF, 32'h1, "edge flag");
        cyc(6'h02);
        idle(3);
        chk("master", master_irq, 32'h1);
        cyc(6'h01);
        idle(2);
        chk("take after enable", takes, 32'h0);
        cyc(6'h21);
        idle(2);
        chk("take in multicycle", takes, 32'h0);
        cyc(6'h08);
        cyc(6'h01);
        idle(2);
        chk("take after multiply", takes, 32'h0);
        cyc(6'h01);
        idle(6);
        chk("take", takes, 32'h1);
        chk("stack", stack_top, 32'h5A3);
        chk("mask after take", global_irq_mask, 32'h1);
        expect_reg(4'h0, 32'hF, 32'h0, "flag ack");
        expect_reg(4'h3, 32'hFFF, 32'h5A3, "core stack");
        dil_src_model_i.set(0, 1'b0);
        idle(5);
        bus(1'b1, 4'h0, 32'h10);
        expect_reg(4'h0, 32'hF, 32'h1, "flag held");
        cyc(6'h02);
        idle(3);
        chk("level master", master_irq, 32'h1);
        cyc(6'h10);
        idle(2);
        chk("mask after status load", global_irq_mask, 32'h0);
        dil_src_model_i.set(0, 1'b1);
        idle(5);
        bus(1'b1, 4'h0, 32'h10);
        expect_reg(4'h0, 32'hF, 32'h0, "flag cleared");
        cyc(6'h04);
        idle(2);
        chk("mask disable", global_irq_mask, 32'h1);
        for (int s = 1; s < 4; s++)
        begin
            cfg = (32'h10 << s) | (s == 3 ? 32'h200 : 32'h0);
            bus(1'b1, 4'h0, cfg);
            dil_src_model_i.pulse(s, 4);
            idle(6);
            expect_reg(4'h0, 32'h2FF, cfg | (32'h1 << s), "frame flag");
        end
        cyc(6'h02);
        idle(3);
        chk("frame master", master_irq, 32'h1);
        bus(1'b1, 4'h0, 32'h20F);
        idle(3);
        chk("source disabled", master_irq, 32'h0);
        cyc(6'h04);
        idle(2);
        bus(1'b1, 4'h0, 32'h1010);
        dil_src_model_i.pulse(0, 4);
        idle(6);
        expect_reg(4'h0, 32'h1, 32'h0, "pin ignored");
        dil_src_model_i.pulse(5, 2);
        idle(6);
        expect_reg(4'h0, 32'h1, 32'h1, "host flag");
        dil_src_model_i.pulse(4, 2);
        bus(1'b1, 4'h0, 32'h1010);
        expect_reg(4'h0, 32'h1, 32'h1, "clear refused");
        dil_src_model_i.pulse(4, 2);
        idle(2);
        bus(1'b1, 4'h0, 32'h1010);
        expect_reg(4'h0, 32'h1, 32'h1, "clear held");
        idle(8);
        bus(1'b1, 4'h0, 32'h1010);
        expect_reg(4'h0, 32'h1, 32'h0, "clear late");
        dil_src_model_i.set(6, 1'b0);
        idle(5);
        chk("test pin ignored", branch_test_eff_n, 32'h1);
        bus(1'b1, 4'h0, 32'h10);
        idle(5);
        chk("test pin", branch_test_eff_n, 32'h0);
        complete_run();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end
endmodule // dil_latch_mux_tb
bind dil_latch_mux dil_latch_mux_checker #(.PC_W(PC_W)) dil_latch_mux_checker_i (
    .ref_clk(ref_clk), .reset(reset), .enable_irq_instr(enable_irq_instr),
    .disable_irq_instr(disable_irq_instr), .core_pc(core_pc), .irq_take(irq_take),
    .discard_fetch(discard_fetch), .stack_push(stack_push), .stack_top(stack_top),
    .pc_load(pc_load), .pc_vector(pc_vector), .global_irq_mask(global_irq_mask));
